// ---- tse_eeprom_top.sv ----
// two-wire serial eeprom target: 256 x 8 array, 16-byte pages
`timescale 1ns/1ps
// Overview of operation
// - Array holds 256 bytes of eight bits, programmed in 16-byte pages.
// - A partial page write programs only the bytes actually received.
// - Programming is self-timed and ends within 5 ms.
// - While power-on reset is asserted, all commands are ignored, nothing written.
// - On power-on reset release, control resets and enters standby.
// - Power-on reset asserting again returns the device to standby.
// - After stop, standby is entered only if no programming is running.
// - Unconnected address-select inputs read as logic zero.
// - Three address-select inputs distinguish up to eight units on one bus.
// - Write-protect high makes the whole array read-only.
// - Write-protect low or open allows normal writes.
// - Data line is only pulled low or released, never driven high.
// - A transfer is target byte, location, then data.
// - Serial clock is input only and times every bit.
// - Target byte is prefix 1010, three select bits, direction bit.
// - Page write advances low four address bits, wrapping inside the page.
// - While programming, address bytes get no acknowledge, allowing polling.
module tse_eeprom_top
#(
    parameter int unsigned WRITE_CYCLES = tse_pkg::PROG_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic power_on_reset,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic addr_select_bit0,
    input  wire logic addr_select_bit1,
    input  wire logic addr_select_bit2,
    input  wire logic write_protect,
    output logic      standby,
    output logic      prog_busy
);
    import tse_pkg::*;

    // ***************************************************************
    // declarations
    // ***************************************************************
    logic [SYNC_W-1:0]     sync_q;
    logic                  scl_s, sda_s, wp_s, por_s;
    logic [2:0]            sel_s;
    logic                  scl_d_reg, sda_d_reg;
    logic                  scl_rise, scl_fall, start_cond, stop_cond;
    tse_state_type         state_reg;
    logic [3:0]            bit_cnt_reg;
    logic [DATA_W-1:0]     shift_reg;
    logic [DATA_W-1:0]     tx_reg;
    logic [ADDR_W-1:0]     ptr_reg;
    logic [DATA_W-1:0]     page_buf_reg [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_vld_reg;
    logic [DATA_W-1:0]     mem_reg [MEM_DEPTH];
    logic                  busy_reg;
    logic [PROG_CNT_W-1:0] prog_cnt_reg;
    logic                  sda_oe_reg, sda_out_reg, standby_reg;
    logic                  in_frame, byte_end, ack_end, mack_rise;
    logic                  dev_match, prog_start, commit;

    // ***************************************************************
    // input synchronisation and bus events
    // ***************************************************************
    tse_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({power_on_reset, write_protect, addr_select_bit2,
                    addr_select_bit1, addr_select_bit0, sda_in, scl_in}),
        .sync_out (sync_q)
    );

    // open select inputs are pulled low at the pad, so they read zero
    assign scl_s = sync_q[SY_SCL];
    assign sda_s = sync_q[SY_SDA];
    assign sel_s = {sync_q[SY_SEL2], sync_q[SY_SEL1], sync_q[SY_SEL0]};
    assign wp_s  = sync_q[SY_WP];
    assign por_s = sync_q[SY_POR];

    // delayed copies for edge detection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // clock edges and start/stop seen while clock is high
    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // byte framing strobes
    assign in_frame  = (state_reg == ST_DEV) || (state_reg == ST_WORD) ||
                       (state_reg == ST_WDATA) || (state_reg == ST_RDATA);
    assign byte_end  = scl_fall && in_frame && (bit_cnt_reg == BIT_LAST);
    assign ack_end   = scl_fall && in_frame && (bit_cnt_reg == BIT_ACK);
    assign mack_rise = scl_rise && (state_reg == ST_RDATA) && (bit_cnt_reg == BIT_ACK);

    // target byte match, refused while programming
    assign dev_match = (shift_reg[7:4] == DEV_PREFIX) && (shift_reg[3:1] == sel_s)
                       && !busy_reg;

    // ***************************************************************
    // bit counter and receive shifter
    // ***************************************************************
    // counts eight data bits plus the ack slot; start parks it on the ack slot
    // so the clock fall that closes the start condition is not taken as a bit
    always_ff @(posedge clk)
    begin
        if (rst || por_s || stop_cond)
            bit_cnt_reg <= 4'h0;
        else if (start_cond)
            bit_cnt_reg <= BIT_ACK;
        else if (scl_fall && in_frame)
            bit_cnt_reg <= (bit_cnt_reg == BIT_ACK) ? 4'h0 : bit_cnt_reg + 4'h1;
    end

    // data bits are taken on the rising clock edge, msb first
    always_ff @(posedge clk)
    begin
        if (rst)
            shift_reg <= 8'h00;
        else if (scl_rise && bit_cnt_reg < BIT_ACK)
            shift_reg <= {shift_reg[6:0], sda_s};
    end

    // ***************************************************************
    // control state machine
    // ***************************************************************
    // target byte, then location, then data
    always_ff @(posedge clk)
    begin
        if (rst || por_s)
            state_reg <= ST_IDLE;
        else if (start_cond)
            state_reg <= ST_DEV;
        else if (stop_cond)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_DEV:
                    if (byte_end)
                        state_reg <= !dev_match ? ST_WAIT :
                                     (shift_reg[0] ? ST_RDATA : ST_WORD);
                ST_WORD:
                    if (byte_end)
                        state_reg <= ST_WDATA;
                ST_RDATA:
                    if (mack_rise && sda_s)
                        state_reg <= ST_WAIT; // master declined more data
                default:
                    state_reg <= state_reg;
            endcase
        end
    end

    // ***************************************************************
    // address pointer and page buffer
    // ***************************************************************
    // location load, page-wrapping write advance, full read advance
    always_ff @(posedge clk)
    begin
        if (rst || por_s)
        begin
            ptr_reg      <= 8'h00;
            page_vld_reg <= 16'h0000;
        end
        else if (byte_end && state_reg == ST_WORD)
        begin
            ptr_reg      <= shift_reg;
            page_vld_reg <= 16'h0000;
        end
        else if (byte_end && state_reg == ST_WDATA)
        begin
            page_vld_reg[ptr_reg[3:0]] <= 1'b1;
            ptr_reg[3:0]               <= ptr_reg[3:0] + 4'h1;
        end
        else if (byte_end && state_reg == ST_RDATA)
            ptr_reg <= ptr_reg + 8'h01;
    end

    // later bytes to the same slot overwrite earlier ones
    always_ff @(posedge clk)
    begin
        if (byte_end && state_reg == ST_WDATA)
            page_buf_reg[ptr_reg[3:0]] <= shift_reg;
    end

    // ***************************************************************
    // self-timed programming
    // ***************************************************************
    assign prog_start = stop_cond && (state_reg == ST_WDATA) && (|page_vld_reg)
                        && !wp_s && !busy_reg;
    assign commit     = busy_reg && (prog_cnt_reg == '0) && !wp_s;

    // busy flag with cycle countdown, cleared by power-on reset
    always_ff @(posedge clk)
    begin
        if (rst || por_s)
        begin
            busy_reg     <= 1'b0;
            prog_cnt_reg <= '0;
        end
        else if (prog_start)
        begin
            busy_reg     <= 1'b1;
            prog_cnt_reg <= PROG_CNT_W'(WRITE_CYCLES - 1);
        end
        else if (busy_reg)
        begin
            if (prog_cnt_reg == '0)
                busy_reg <= 1'b0;
            else
                prog_cnt_reg <= prog_cnt_reg - PROG_CNT_W'(1);
        end
    end

    // each cell takes its buffered byte when its page slot was received
    genvar gi;
    generate
        for (gi = 0; gi < MEM_DEPTH; gi++)
        begin : g_cell
            localparam logic [ADDR_W-1:0] CELL = ADDR_W'(gi);
            always_ff @(posedge clk)
            begin
                if (commit && ptr_reg[7:4] == CELL[7:4] && page_vld_reg[CELL[3:0]])
                    mem_reg[gi] <= page_buf_reg[CELL[3:0]];
            end
        end
    endgenerate

    // ***************************************************************
    // data line drive
    // ***************************************************************
    // transmit shifter, loaded after each acknowledge slot
    always_ff @(posedge clk)
    begin
        if (rst)
            tx_reg <= 8'h00;
        else if (ack_end && state_reg == ST_RDATA)
            tx_reg <= mem_reg[ptr_reg];
        else if (scl_fall && state_reg == ST_RDATA && bit_cnt_reg < BIT_LAST)
            tx_reg <= {tx_reg[6:0], 1'b0};
    end

    // pull low for acknowledge or a zero data bit, else release
    always_ff @(posedge clk)
    begin
        if (rst || por_s || start_cond || stop_cond)
            sda_oe_reg <= 1'b0;
        else if (byte_end)
            sda_oe_reg <= (state_reg == ST_DEV) ? dev_match :
                          (state_reg == ST_WORD || state_reg == ST_WDATA);
        else if (ack_end)
            sda_oe_reg <= (state_reg == ST_RDATA) ? ~mem_reg[ptr_reg][7] : 1'b0;
        else if (scl_fall && state_reg == ST_RDATA && bit_cnt_reg < BIT_LAST)
            sda_oe_reg <= ~tx_reg[6];
    end

    // driven level is always low
    always_ff @(posedge clk)
    begin
        sda_out_reg <= 1'b0;
    end

    // standby once idle and not programming
    always_ff @(posedge clk)
    begin
        if (rst)
            standby_reg <= 1'b1;
        else
            standby_reg <= por_s || (state_reg == ST_IDLE && !busy_reg);
    end

    assign sda_oe    = sda_oe_reg;
    assign sda_out   = sda_out_reg;
    assign standby   = standby_reg;
    assign prog_busy = busy_reg;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [PROG_CNT_W-1:0] busy_len_reg;
    // counts cycles of one programming run
    always_ff @(posedge clk)
    begin
        if (rst || !busy_reg)
            busy_len_reg <= '0;
        else
            busy_len_reg <= busy_len_reg + PROG_CNT_W'(1);
    end

    sda_low_only_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    por_quiet_a: assert property (por_s |=> !sda_oe && !prog_busy && standby)
        else $error("activity during power-on reset");
    por_release_a: assert property ($fell(por_s) |-> state_reg == ST_IDLE ##1 standby)
        else $error("no standby after power-on reset release");
    por_again_a: assert property ($rose(por_s) |=> state_reg == ST_IDLE ##1 standby)
        else $error("no standby after power-on reset");
    stop_standby_a: assert property (stop_cond && !busy_reg && !prog_start
                                     |=> state_reg == ST_IDLE ##1 standby)
        else $error("stop did not lead to standby");
    busy_no_standby_a: assert property (busy_reg && $past(busy_reg) |-> !standby)
        else $error("standby while programming");
    prog_time_a: assert property (busy_reg |-> busy_len_reg < PROG_CNT_W'(WRITE_CYCLES))
        else $error("programming exceeds its time");
    prog_run_a: assert property (prog_start |=> prog_busy [*8])
        else $error("programming ended early");
    poll_nack_a: assert property (byte_end && state_reg == ST_DEV && busy_reg
                                  |=> !sda_oe ##1 !sda_oe)
        else $error("acknowledge while programming");
    addr_ack_a: assert property (byte_end && state_reg == ST_DEV && !busy_reg &&
                                 shift_reg[7:1] == {DEV_PREFIX, sel_s}
                                 |=> sda_oe throughout (!scl_fall)[*1])
        else $error("matching target not acknowledged");
    addr_miss_a: assert property (byte_end && state_reg == ST_DEV &&
                                  shift_reg[7:1] != {DEV_PREFIX, sel_s}
                                  |=> !sda_oe && state_reg == ST_WAIT)
        else $error("foreign target acknowledged");
    wp_refuse_a: assert property (stop_cond && wp_s && !busy_reg |=> !prog_busy)
        else $error("programming started under write protect");
    wp_commit_a: assert property (commit |-> !wp_s && $past(busy_reg))
        else $error("array changed under write protect");
    wp_low_a: assert property (stop_cond && state_reg == ST_WDATA && page_vld_reg[0]
                               && !wp_s && !busy_reg |=> prog_busy)
        else $error("write refused while unprotected");
    page_wrap_a: assert property (byte_end && state_reg == ST_WDATA
                                  |=> ptr_reg[7:4] == $past(ptr_reg[7:4]) &&
                                      ptr_reg[3:0] == $past(ptr_reg[3:0]) + 4'h1)
        else $error("page address advance wrong");
    ack_slot_a: assert property (sda_oe && state_reg != ST_RDATA
                                 |-> bit_cnt_reg == BIT_ACK)
        else $error("pull-down outside acknowledge slot");

    write_cov_c: cover property (prog_start ##1 prog_busy);
    read_cov_c: cover property (ack_end && state_reg == ST_RDATA);
    poll_cov_c: cover property (byte_end && state_reg == ST_DEV && busy_reg);
    wp_cov_c: cover property (stop_cond && state_reg == ST_WDATA && wp_s);
endmodule

// ---- tse_pkg.sv ----
// package: constants and types for the two-wire serial eeprom
package tse_pkg;
    // ***************************************************************
    // array geometry
    // ***************************************************************
    localparam int MEM_DEPTH  = 256;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_W     = 4;

    // ***************************************************************
    // bus framing
    // ***************************************************************
    localparam logic [3:0] DEV_PREFIX = 4'hA;
    localparam logic [3:0] BIT_LAST   = 4'h7;
    localparam logic [3:0] BIT_ACK    = 4'h8;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_MHZ      = 250;
    localparam int PROG_TIME_MS = 5;
    localparam int PROG_CYCLES  = PROG_TIME_MS * 1000 * CLK_MHZ;
    localparam int PROG_CNT_W   = 21;

    // ***************************************************************
    // input synchroniser: {por, wp, sel2, sel1, sel0, sda, scl}
    // ***************************************************************
    localparam int         SYNC_W   = 7;
    localparam logic [6:0] SYNC_RST = 7'h43;
    localparam int         SY_SCL   = 0;
    localparam int         SY_SDA   = 1;
    localparam int         SY_SEL0  = 2;
    localparam int         SY_SEL1  = 3;
    localparam int         SY_SEL2  = 4;
    localparam int         SY_WP    = 5;
    localparam int         SY_POR   = 6;

    // ***************************************************************
    // control states
    // ***************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_DEV   = 6'h02,
        ST_WORD  = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_WAIT  = 6'h20
    } tse_state_type;
endpackage

// ---- tse_sync.sv ----
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module tse_sync
#(
    parameter int         WIDTH   = tse_pkg::SYNC_W,
    parameter logic [6:0] RST_VAL = tse_pkg::SYNC_RST
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import tse_pkg::*;

    // ***************************************************************
    // one two-stage chain per bit
    // ***************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_reg;
            // first stage feeds only the second stage
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    meta_reg     <= RST_VAL[gi];
                    sync_out[gi] <= RST_VAL[gi];
                end
                else
                begin
                    meta_reg     <= async_in[gi];
                    sync_out[gi] <= meta_reg;
                end
            end
        end
    endgenerate
endmodule

// ---- tse_master.sv ----
// bus master model that drives the two-wire link from the far side
`timescale 1ns/1ps
module tse_master
#(
    parameter int QTR = 10
)
(
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_pull
);
    // ***************************************************************
    // idle bus: clock high and still, data released
    // ***************************************************************
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // one quarter of the 160 ns link period, launched just after an edge
    task automatic tick();
        repeat (QTR) @(posedge clk);
        #1;
    endtask

    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_pull = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask

    // stop: data rises while the clock is high, clock then stands still
    task automatic stop();
        sda_pull = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b0;
        tick();
    endtask

    // one bit: data set while clock low, wire sampled mid high phase
    task automatic xfer(input logic b, output logic r);
        sda_pull = ~b;
        tick();
        scl = 1'b1;
        tick();
        r = sda_wire;
        tick();
        scl = 1'b0;
        tick();
    endtask

    // byte out msb first, then the ninth slot returns the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask

    // byte in msb first; last byte answered with no acknowledge
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(last, r);
    endtask
endmodule

// ---- tse_eeprom_bench.sv ----
// self-checking bench for the two-wire serial eeprom target
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tse_eeprom_bench;
    import tse_pkg::*;
    localparam int WC   = 2000;
    localparam int CEIL = 60000;
    logic       clk, rst, por, wp, sda_wire, sda_out, sda_oe;
    logic       scl, m_pull, standby, prog_busy, commit_ok, a;
    logic [2:0] sel;
    logic [7:0] exp_mem [0:255];
    int         n_fail, num_checks, cyc, busy_cnt, last_len;

    always #2 clk = ~clk;
    // open-drain wire with pull-up
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~m_pull;

    tse_eeprom_top #(.WRITE_CYCLES(WC)) tse_eeprom_top_inst (
        .clk(clk), .rst(rst), .power_on_reset(por), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_bit0(sel[0]),
        .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .write_protect(wp),
        .standby(standby), .prog_busy(prog_busy));

    tse_master tse_master_inst (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(m_pull));

    // ***************************************************************
    // verdict and run end
    // ***************************************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // busy length, data pin polarity and hang guard
    always @(negedge clk)
    begin
        cyc++;
        if (prog_busy === 1'b1) busy_cnt++;
        else if (busy_cnt != 0)
        begin
            last_len = busy_cnt;
            busy_cnt = 0;
        end
        if (sda_oe === 1'b1) `CHK(sda_out, 1'b0)
        if (cyc == CEIL)
        begin
            n_fail++;
            $display("[ERR] %0t run hung", $time);
            conclude();
        end
    end

    task automatic clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic dev(input logic rw, output logic ack);
        tse_master_inst.wbyte({DEV_PREFIX, sel, rw}, ack);
    endtask

    // page write; the expected image keeps only bytes that may land
    task automatic page_wr(input logic [7:0] loc, input int n, input logic [7:0] base);
        logic [3:0] lo;
        tse_master_inst.start();
        dev(1'b0, a);
        `CHK(a, 1'b1)
        tse_master_inst.wbyte(loc, a);
        `CHK(a, 1'b1)
        for (int k = 0; k < n; k++)
        begin
            lo = loc[3:0] + k[3:0];
            tse_master_inst.wbyte(base + k[7:0], a);
            `CHK(a, 1'b1)
            if (commit_ok && !wp) exp_mem[{loc[7:4], lo}] = base + k[7:0];
        end
        tse_master_inst.stop();
    endtask

    // poll during programming, then wait for the self-timed end
    task automatic prog_wait();
        clks(8);
        `CHK(prog_busy, 1'b1)
        `CHK(standby, 1'b0)
        tse_master_inst.start();
        dev(1'b0, a);
        `CHK(a, 1'b0)
        tse_master_inst.stop();
        for (int i = 0; i < WC && prog_busy !== 1'b0; i++) clks(1);
        clks(1);
        `CHK(prog_busy, 1'b0)
        `CHK(standby, 1'b1)
        `CHK(last_len >= WC - 1 && last_len <= WC + 1, 1'b1)
    endtask

    // random address read followed by sequential bytes
    task automatic rd_seq(input logic [7:0] loc, input int n);
        logic [7:0] d;
        tse_master_inst.start();
        dev(1'b0, a);
        `CHK(a, 1'b1)
        tse_master_inst.wbyte(loc, a);
        tse_master_inst.start();
        dev(1'b1, a);
        `CHK(a, 1'b1)
        for (int k = 0; k < n; k++)
        begin
            tse_master_inst.rbyte(k == n - 1, d);
            `CHK(d, exp_mem[loc + k[7:0]])
        end
        tse_master_inst.stop();
    endtask

    // ***************************************************************
    // test sequence
    // ***************************************************************
    initial
    begin
        clk = 1'b0; rst = 1'b1; por = 1'b1; wp = 1'b0; sel = 3'h5; commit_ok = 1'b1;
        n_fail = 0; num_checks = 0; cyc = 0; busy_cnt = 0; last_len = 0;
        clks(12);
        rst = 1'b0;
        clks(8);
        // commands under power-on reset are ignored
        tse_master_inst.start();
        dev(1'b0, a);
        `CHK(a, 1'b0)
        tse_master_inst.stop();
        `CHK(prog_busy, 1'b0)
        `CHK(standby, 1'b1)
        por = 1'b0;
        clks(8);
        `CHK(standby, 1'b1)
        $display("end of test: power-on reset");
        // only the strapped select value is answered
        for (int i = 0; i < 8; i++)
        begin
            tse_master_inst.start();
            tse_master_inst.wbyte({DEV_PREFIX, i[2:0], 1'b0}, a);
            `CHK(a, i[2:0] == sel)
            tse_master_inst.stop();
        end
        $display("end of test: address select");
        // overlong wrapping page, then a partial page inside it
        page_wr(8'h1E, 18, 8'h40);
        prog_wait();
        page_wr(8'h12, 3, 8'hC0);
        prog_wait();
        rd_seq(8'h10, 16);
        $display("end of test: page write");
        // protected write changes nothing and starts nothing
        wp = 1'b1;
        clks(8);
        page_wr(8'h13, 1, 8'h55);
        clks(20);
        `CHK(prog_busy, 1'b0)
        `CHK(standby, 1'b1)
        wp = 1'b0;
        clks(8);
        rd_seq(8'h13, 1);
        $display("end of test: write protect");
        // power-on reset during programming aborts it
        commit_ok = 1'b0;
        page_wr(8'h15, 1, 8'h77);
        clks(8);
        `CHK(prog_busy, 1'b1)
        por = 1'b1;
        clks(6);
        `CHK(prog_busy, 1'b0)
        `CHK(standby, 1'b1)
        por = 1'b0;
        commit_ok = 1'b1;
        clks(8);
        $display("end of test: reset abort");
        // straps driven low as when left open
        sel = 3'h0;
        clks(8);
        page_wr(8'h15, 1, 8'h3C);
        prog_wait();
        rd_seq(8'h10, 16);
        $display("end of test: default straps");
        conclude();
    end
endmodule
